// [ufc_cfg.svh]
// Offsets, reset values, encodings and timing constants of the function control block.
`ifndef UFC_CFG_SVH
`define UFC_CFG_SVH

`define UFC_ADDR_W        4
`define UFC_OFS_FUNC      4'h0
`define UFC_OFS_FUNC_SET  4'h1
`define UFC_OFS_FUNC_CLR  4'h2
`define UFC_OFS_PULLDOWN  4'h3
`define UFC_OFS_STATUS    4'h4

`define UFC_FUNC_RST      8'h41
`define UFC_FUNC_MASK     8'h7f
`define UFC_CLR_MASK      8'h5f
`define UFC_PD_RST        8'h00
`define UFC_PD_MASK       8'h03

`define UFC_XS_HS         2'h0
`define UFC_XS_FS         2'h1
`define UFC_XS_LS         2'h2
`define UFC_XS_FS4LS      2'h3

`define UFC_OPM_NORMAL    2'h0
`define UFC_OPM_NONDRV    2'h1
`define UFC_OPM_NOSTUFF   2'h2
`define UFC_OPM_NOAUTO    2'h3

`define UFC_CLK_MHZ       125
`define UFC_XRST_NS       200
`define UFC_XRST_CYC      ((`UFC_XRST_NS * `UFC_CLK_MHZ + 999) / 1000)
`define UFC_CNT_W         8

`endif

// [ufc_pkg.sv]
// Types shared by the function control block and its helpers.
package ufc_pkg;
`include "ufc_cfg.svh"

    typedef struct packed {
        logic       rsvd;
        logic       suspend_n;
        logic       xcvr_reset;
        logic [1:0] operating_encoding_mode;
        logic       termination_select;
        logic [1:0] transceiver_speed_select;
    } ufc_func_s;

    typedef struct packed {
        logic [5:0] rsvd;
        logic       negative_line_pulldown;
        logic       positive_line_pulldown;
    } ufc_pd_s;

    typedef struct packed {
        logic [4:0] rsvd;
        logic       reset_busy;
        logic       ulpi_dir;
        logic       low_power;
    } ufc_stat_s;

    typedef struct packed {
        logic hs_term_en;
        logic dp_pullup_en;
        logic dm_pullup_en;
    } ufc_term_s;

    typedef struct packed {
        logic      hs_xcvr_en;
        logic      fs_xcvr_en;
        logic      ls_xcvr_en;
        logic      fs_preamble_en;
        logic      tx_nondriving;
        logic      bitstuff_en;
        logic      nrzi_en;
        logic      auto_sync_eop_en;
        ufc_term_s term;
        logic      low_power;
        logic      fs_rx_en;
        logic      otg_comp_en;
    } ufc_ctrl_s;

    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_RESET = 2'b01,
        SEQ_GAP   = 2'b10,
        SEQ_RXCMD = 2'b11
    } ufc_seq_e;

    typedef struct packed {
        ufc_seq_e                st;
        logic [`UFC_CNT_W-1:0]   cnt;
        logic                    dir;
        logic                    xrst;
        logic                    done;
        logic                    rxcmd;
    } ufc_seq_st_s;

    typedef struct packed {
        ufc_func_s func;
        ufc_pd_s   pd;
        logic [7:0] rdata;
        ufc_ctrl_s ctrl;
    } ufc_top_st_s;

endpackage

// [ufc_term_dec.sv]
// Decodes which bus resistors the termination select bit switches on.
`timescale 1ns/10ps
`include "ufc_cfg.svh"
module ufc_term_dec import ufc_pkg::*; #(
    parameter bit LS_DM_PULLUP = 1'b1
) (
    input  ufc_func_s func,
    input  ufc_pd_s   pd,
    output ufc_term_s term
);

    logic host_mode;

    assign host_mode = pd.positive_line_pulldown & pd.negative_line_pulldown;

    always_comb begin
        term = '0;
        if (host_mode) begin
            term.hs_term_en = (func.transceiver_speed_select == `UFC_XS_HS)
                              && !func.termination_select;
        end else begin
            unique case (func.transceiver_speed_select)
                `UFC_XS_HS: begin
                    term.dp_pullup_en = func.termination_select;
                    term.hs_term_en   = !func.termination_select
                                        && (func.operating_encoding_mode != `UFC_OPM_NONDRV);
                end
                `UFC_XS_FS, `UFC_XS_FS4LS: begin
                    term.dp_pullup_en = func.termination_select;
                end
                `UFC_XS_LS: begin
                    term.dm_pullup_en = func.termination_select & LS_DM_PULLUP;
                end
            endcase
        end
    end

endmodule

// [ufc_xrst_seq.sv]
// Sequences the software transceiver reset handshake on the direction signal.
`timescale 1ns/10ps
`include "ufc_cfg.svh"
module ufc_xrst_seq import ufc_pkg::*; (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic req,
    output ufc_seq_st_s seq
);

    localparam int XRST_LEN = `UFC_XRST_CYC;

    ufc_seq_st_s seq_ff;
    ufc_seq_st_s nxt_seq;

    always_comb begin
        nxt_seq       = seq_ff;
        nxt_seq.done  = 1'b0;
        nxt_seq.rxcmd = 1'b0;
        unique case (seq_ff.st)
            SEQ_IDLE: begin
                nxt_seq.dir = 1'b0;
                if (req) begin
                    nxt_seq.st   = SEQ_RESET;
                    nxt_seq.dir  = 1'b1;
                    nxt_seq.xrst = 1'b1;
                    nxt_seq.cnt  = `UFC_CNT_W'(XRST_LEN - 1);
                end
            end
            SEQ_RESET: begin
                if (seq_ff.cnt == '0) begin
                    nxt_seq.st   = SEQ_GAP;
                    nxt_seq.dir  = 1'b0;
                    nxt_seq.xrst = 1'b0;
                    nxt_seq.done = 1'b1;
                end else begin
                    nxt_seq.cnt = seq_ff.cnt - `UFC_CNT_W'(1);
                end
            end
            SEQ_GAP: begin
                nxt_seq.st    = SEQ_RXCMD;
                nxt_seq.dir   = 1'b1;
                nxt_seq.rxcmd = 1'b1;
            end
            SEQ_RXCMD: begin
                nxt_seq.st  = SEQ_IDLE;
                nxt_seq.dir = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_ff <= '0;
        end else begin
            seq_ff <= nxt_seq;
        end
    end

    assign seq = seq_ff;

    a_dir_in_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
        (seq_ff.st == SEQ_RESET) |-> (seq_ff.dir && seq_ff.xrst))
        else $error("Direction or transceiver reset low while resetting.");

    a_reset_length: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(seq_ff.xrst) |-> ##XRST_LEN (!seq_ff.xrst && !seq_ff.dir && seq_ff.done))
        else $error("Transceiver reset did not end with direction low on time.");

    a_rxcmd_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_ff.done |-> ##1 (seq_ff.dir && seq_ff.rxcmd) ##1 (!seq_ff.dir && !seq_ff.rxcmd))
        else $error("Status update did not follow the end of transceiver reset.");

endmodule

// [ufc_func_ctrl.sv]
// Transceiver function control register bank with reset handshake and resistor control.
//
// Functional notes
// - Termination select drives pull-up and HS termination.
// - Resistor choice depends on speed, mode, pulldowns.
// - Low-speed negative-line pull-up is optional.
// - Mode 00 normal, mode 01 non-driving.
// - Mode 10 disables bit stuffing and NRZI.
// - Mode 11 disables automatic SYNC and EOP.
// - Reset bit raises direction, resets transceiver.
// - Reset end drops direction, clears the bit.
// - Then raise direction again, send status update.
// - Transceiver reset leaves registers and interface intact.
// - Suspend bit low enters low-power mode.
// - Low power keeps FS receiver, comparators, pins.
// - Speed 11 uses FS transceiver with preamble.
// - Speed 00 HS, 01 FS, 10 LS.
`timescale 1ns/10ps
`include "ufc_cfg.svh"
module ufc_func_ctrl import ufc_pkg::*; #(
    parameter bit LS_DM_PULLUP = 1'b1
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    input  wire logic [`UFC_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic [7:0]                  reg_rdata,
    output logic                        ulpi_dir,
    output logic                        rx_cmd_send,
    output logic                        xcvr_rst,
    output ufc_ctrl_s                   phy_ctrl
);

    localparam ufc_ctrl_s CTRL_RST = '{
        fs_xcvr_en:       1'b1,
        bitstuff_en:      1'b1,
        nrzi_en:          1'b1,
        auto_sync_eop_en: 1'b1,
        fs_rx_en:         1'b1,
        otg_comp_en:      1'b1,
        default:          '0
    };

    localparam ufc_top_st_s ST_RST = '{
        func:  ufc_func_s'(`UFC_FUNC_RST),
        pd:    ufc_pd_s'(`UFC_PD_RST),
        rdata: 8'h00,
        ctrl:  CTRL_RST
    };

    ufc_top_st_s st_ff;
    ufc_top_st_s nxt_st;
    ufc_seq_st_s seq;
    ufc_term_s   term;
    ufc_stat_s   status;
    ufc_func_s   wr_func;
    logic        low_pwr;

    ufc_xrst_seq u_xrst_seq (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .req      (st_ff.func.xcvr_reset),
        .seq      (seq)
    );

    ufc_term_dec #(
        .LS_DM_PULLUP (LS_DM_PULLUP)
    ) u_term_dec (
        .func (st_ff.func),
        .pd   (st_ff.pd),
        .term (term)
    );

    assign wr_func = ufc_func_s'(reg_wdata & `UFC_FUNC_MASK);
    assign low_pwr = !st_ff.func.suspend_n;

    always_comb begin
        status            = '0;
        status.reset_busy = (seq.st != SEQ_IDLE) || st_ff.func.xcvr_reset;
        status.ulpi_dir   = seq.dir;
        status.low_power  = st_ff.ctrl.low_power;
    end

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.rdata = 8'h00;

        // Hardware clears the reset bit; a set in the same cycle wins.
        if (seq.done) begin
            nxt_st.func.xcvr_reset = 1'b0;
        end

        if (reg_wr) begin
            case (reg_addr)
                `UFC_OFS_FUNC: begin
                    nxt_st.func            = wr_func;
                    nxt_st.func.xcvr_reset = (st_ff.func.xcvr_reset & !seq.done)
                                             | wr_func.xcvr_reset;
                end
                `UFC_OFS_FUNC_SET: begin
                    nxt_st.func = ufc_func_s'(8'(nxt_st.func) | 8'(wr_func));
                end
                `UFC_OFS_FUNC_CLR: begin
                    nxt_st.func = ufc_func_s'(8'(nxt_st.func)
                                  & ~(reg_wdata & `UFC_CLR_MASK));
                end
                `UFC_OFS_PULLDOWN: begin
                    nxt_st.pd = ufc_pd_s'(reg_wdata & `UFC_PD_MASK);
                end
                default: begin
                    nxt_st.pd = st_ff.pd;
                end
            endcase
        end

        if (reg_rd) begin
            case (reg_addr)
                `UFC_OFS_FUNC, `UFC_OFS_FUNC_SET, `UFC_OFS_FUNC_CLR: begin
                    nxt_st.rdata = 8'(st_ff.func);
                end
                `UFC_OFS_PULLDOWN: begin
                    nxt_st.rdata = 8'(st_ff.pd);
                end
                `UFC_OFS_STATUS: begin
                    nxt_st.rdata = 8'(status);
                end
                default: begin
                    nxt_st.rdata = 8'h00;
                end
            endcase
        end

        // Transceiver controls; the transceiver reset does not touch them.
        nxt_st.ctrl.hs_xcvr_en = !low_pwr
            && (st_ff.func.transceiver_speed_select == `UFC_XS_HS);
        nxt_st.ctrl.fs_xcvr_en = !low_pwr
            && ((st_ff.func.transceiver_speed_select == `UFC_XS_FS)
            || (st_ff.func.transceiver_speed_select == `UFC_XS_FS4LS));
        nxt_st.ctrl.ls_xcvr_en = !low_pwr
            && (st_ff.func.transceiver_speed_select == `UFC_XS_LS);
        nxt_st.ctrl.fs_preamble_en =
            (st_ff.func.transceiver_speed_select == `UFC_XS_FS4LS);
        nxt_st.ctrl.tx_nondriving =
            (st_ff.func.operating_encoding_mode == `UFC_OPM_NONDRV);
        nxt_st.ctrl.bitstuff_en =
            (st_ff.func.operating_encoding_mode != `UFC_OPM_NOSTUFF);
        nxt_st.ctrl.nrzi_en =
            (st_ff.func.operating_encoding_mode != `UFC_OPM_NOSTUFF);
        nxt_st.ctrl.auto_sync_eop_en =
            (st_ff.func.operating_encoding_mode != `UFC_OPM_NOAUTO);
        nxt_st.ctrl.term        = term;
        nxt_st.ctrl.low_power   = low_pwr;
        nxt_st.ctrl.fs_rx_en    = 1'b1;
        nxt_st.ctrl.otg_comp_en = 1'b1;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata   = st_ff.rdata;
    assign phy_ctrl    = st_ff.ctrl;
    assign ulpi_dir    = seq.dir;
    assign rx_cmd_send = seq.rxcmd;
    assign xcvr_rst    = seq.xrst;

    a_term_device_hs: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!st_ff.pd.positive_line_pulldown
         && (st_ff.func.transceiver_speed_select == `UFC_XS_HS)
         && st_ff.func.termination_select)
        |=> (st_ff.ctrl.term.dp_pullup_en && !st_ff.ctrl.term.hs_term_en))
        else $error("Termination select did not give the full-speed pull-up.");

    a_term_host_hs: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_ff.pd.positive_line_pulldown && st_ff.pd.negative_line_pulldown
         && (st_ff.func.transceiver_speed_select == `UFC_XS_HS)
         && !st_ff.func.termination_select)
        |=> (st_ff.ctrl.term.hs_term_en && !st_ff.ctrl.term.dp_pullup_en
             && !st_ff.ctrl.term.dm_pullup_en))
        else $error("Host-side high-speed termination decoded wrongly.");

    a_ls_pullup_opt: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!st_ff.pd.positive_line_pulldown
         && (st_ff.func.transceiver_speed_select == `UFC_XS_LS)
         && st_ff.func.termination_select)
        |=> (st_ff.ctrl.term.dm_pullup_en == LS_DM_PULLUP) && !st_ff.ctrl.term.dp_pullup_en)
        else $error("Low-speed pull-up did not follow its option.");

    a_mode_nondrv: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_ff.func.operating_encoding_mode == `UFC_OPM_NONDRV)
        |=> (st_ff.ctrl.tx_nondriving && st_ff.ctrl.bitstuff_en))
        else $error("Non-driving mode not applied.");

    a_mode_nostuff: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_ff.func.operating_encoding_mode == `UFC_OPM_NOSTUFF)
        |=> (!st_ff.ctrl.bitstuff_en && !st_ff.ctrl.nrzi_en && st_ff.ctrl.auto_sync_eop_en))
        else $error("Bit stuffing or NRZI still enabled.");

    a_mode_noauto: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_ff.func.operating_encoding_mode == `UFC_OPM_NOAUTO)
        |=> (!st_ff.ctrl.auto_sync_eop_en && st_ff.ctrl.nrzi_en))
        else $error("Automatic SYNC and EOP still enabled.");

    a_reset_starts: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(st_ff.func.xcvr_reset) |-> ##[1:3] (ulpi_dir && xcvr_rst))
        else $error("Reset bit did not raise direction and transceiver reset.");

    a_bit_self_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (seq.done && !(reg_wr && reg_wdata[5]
         && ((reg_addr == `UFC_OFS_FUNC) || (reg_addr == `UFC_OFS_FUNC_SET))))
        |=> !st_ff.func.xcvr_reset)
        else $error("Reset bit not cleared at the end of transceiver reset.");

    a_regs_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
        (xcvr_rst && !reg_wr)
        |=> ($stable(st_ff.pd) && $stable(st_ff.func.suspend_n)
             && $stable(st_ff.func.operating_encoding_mode)
             && $stable(st_ff.func.termination_select)
             && $stable(st_ff.func.transceiver_speed_select)))
        else $error("Transceiver reset disturbed register contents.");

    a_low_power: assert property (@(posedge core_clk) disable iff (!rst_n)
        !st_ff.func.suspend_n |=> (st_ff.ctrl.low_power && !st_ff.ctrl.hs_xcvr_en))
        else $error("Suspend did not enter low-power mode.");

    a_keep_alive: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_ff.ctrl.low_power |-> (st_ff.ctrl.fs_rx_en && st_ff.ctrl.otg_comp_en
            && !st_ff.ctrl.hs_xcvr_en && !st_ff.ctrl.fs_xcvr_en && !st_ff.ctrl.ls_xcvr_en))
        else $error("Receiver or comparators powered down in low power.");

    a_fs_for_ls: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_ff.func.suspend_n && (st_ff.func.transceiver_speed_select == `UFC_XS_FS4LS))
        |=> (st_ff.ctrl.fs_xcvr_en && st_ff.ctrl.fs_preamble_en && !st_ff.ctrl.ls_xcvr_en))
        else $error("Full-speed transceiver for low-speed packets not selected.");

    a_speed_ls: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_ff.func.suspend_n && (st_ff.func.transceiver_speed_select == `UFC_XS_LS))
        |=> (st_ff.ctrl.ls_xcvr_en && !st_ff.ctrl.fs_xcvr_en && !st_ff.ctrl.hs_xcvr_en))
        else $error("Low-speed transceiver not selected.");

    a_set_alias: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_wr && (reg_addr == `UFC_OFS_FUNC_SET) && !seq.done)
        |=> (8'(st_ff.func) == ((8'($past(st_ff.func)) | $past(reg_wdata)) & `UFC_FUNC_MASK)))
        else $error("Set alias changed bits not written as one.");

    a_clr_alias: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_wr && (reg_addr == `UFC_OFS_FUNC_CLR) && !seq.done)
        |=> (8'(st_ff.func) == (8'($past(st_ff.func)) & ~($past(reg_wdata) & `UFC_CLR_MASK))))
        else $error("Clear alias changed bits not written as one.");

    a_speed_hs: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_ff.func.suspend_n && (st_ff.func.transceiver_speed_select == `UFC_XS_HS))
        |=> (st_ff.ctrl.hs_xcvr_en && !st_ff.ctrl.fs_xcvr_en && !st_ff.ctrl.ls_xcvr_en))
        else $error("High-speed transceiver not selected.");

    a_speed_fs: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_ff.func.suspend_n && (st_ff.func.transceiver_speed_select == `UFC_XS_FS))
        |=> (st_ff.ctrl.fs_xcvr_en && !st_ff.ctrl.hs_xcvr_en && !st_ff.ctrl.ls_xcvr_en
             && !st_ff.ctrl.fs_preamble_en))
        else $error("Full-speed transceiver not selected.");

    a_preamble_only: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_ff.func.transceiver_speed_select != `UFC_XS_FS4LS) |=> !st_ff.ctrl.fs_preamble_en)
        else $error("Preamble enabled outside the full-speed-for-low-speed setting.");

    a_mode_normal: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_ff.func.operating_encoding_mode == `UFC_OPM_NORMAL)
        |=> (!st_ff.ctrl.tx_nondriving && st_ff.ctrl.bitstuff_en && st_ff.ctrl.nrzi_en
             && st_ff.ctrl.auto_sync_eop_en))
        else $error("Normal mode not applied.");

    a_term_device_fs: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!st_ff.pd.positive_line_pulldown
         && ((st_ff.func.transceiver_speed_select == `UFC_XS_FS)
          || (st_ff.func.transceiver_speed_select == `UFC_XS_FS4LS)))
        |=> ((st_ff.ctrl.term.dp_pullup_en == $past(st_ff.func.termination_select))
             && !st_ff.ctrl.term.hs_term_en && !st_ff.ctrl.term.dm_pullup_en))
        else $error("Full-speed pull-up did not follow termination select.");

    a_term_nondrv: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!st_ff.pd.positive_line_pulldown
         && (st_ff.func.transceiver_speed_select == `UFC_XS_HS)
         && (st_ff.func.operating_encoding_mode == `UFC_OPM_NONDRV))
        |=> !st_ff.ctrl.term.hs_term_en)
        else $error("High-speed termination on in non-driving mode.");

    a_reset_bit_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_wr && (reg_addr == `UFC_OFS_FUNC) && wr_func.xcvr_reset) |=> st_ff.func.xcvr_reset)
        else $error("Writing the reset bit did not set it.");

    a_idle_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        ((seq.st == SEQ_IDLE) && !st_ff.func.xcvr_reset) |=> (!ulpi_dir && !xcvr_rst))
        else $error("Direction or transceiver reset raised without a request.");

    a_status_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_rd && (reg_addr == `UFC_OFS_STATUS)) |=> (reg_rdata == 8'($past(status))))
        else $error("Status read did not show direction and low power.");

endmodule

// [ufc_link_model.sv]
// Link controller model that tracks the reset handshake on the direction signal.
`timescale 1ns/10ps
module ufc_link_model (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic rst_req,
    input  wire logic ulpi_dir,
    input  wire logic rx_cmd_send,
    output logic      bus_ok,
    output int        rxcmd_cnt
);
    logic dir_seen;

    // The bus stays closed from a reset request until direction has risen and dropped.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_ok    <= 1'b1;
            dir_seen  <= 1'b0;
            rxcmd_cnt <= 0;
        end else begin
            if (rx_cmd_send) begin
                rxcmd_cnt <= rxcmd_cnt + 1;
            end
            if (rst_req) begin
                bus_ok   <= 1'b0;
                dir_seen <= 1'b0;
            end else if (!bus_ok && ulpi_dir) begin
                dir_seen <= 1'b1;
            end else if (!bus_ok && dir_seen) begin
                bus_ok   <= 1'b1;
            end
        end
    end
endmodule

// [ufc_func_ctrl_tb.sv]
// Self-checking bench for the function control register bank.
`timescale 1ns/10ps
`include "ufc_cfg.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module ufc_func_ctrl_tb import ufc_pkg::*; ();
    localparam bit LSDM = 1'b1;
    // Rows: function value, pulldown value, expected hs_term/dp/dm.
    localparam logic [23:0] TROWS [8] = '{24'h410000, 24'h450002, 24'h400004,
        24'h440002, 24'h480000, 24'h460001, 24'h470002, 24'h400304};
    logic                   core_clk;
    logic                   rst_n;
    logic [`UFC_ADDR_W-1:0] reg_addr;
    logic [7:0]             reg_wdata;
    logic                   reg_wr;
    logic                   reg_rd;
    logic [7:0]             reg_rdata;
    logic                   ulpi_dir;
    logic                   rx_cmd_send;
    logic                   xcvr_rst;
    ufc_ctrl_s              phy_ctrl;
    logic                   rst_req;
    logic                   bus_ok;
    int                     rxcmd_cnt;
    int                     fail_count;
    int                     n_checks;
    logic [7:0]             rd_val;

    ufc_func_ctrl #(.LS_DM_PULLUP(LSDM)) DUT (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .reg_addr    (reg_addr),
        .reg_wdata   (reg_wdata),
        .reg_wr      (reg_wr),
        .reg_rd      (reg_rd),
        .reg_rdata   (reg_rdata),
        .ulpi_dir    (ulpi_dir),
        .rx_cmd_send (rx_cmd_send),
        .xcvr_rst    (xcvr_rst),
        .phy_ctrl    (phy_ctrl)
    );

    ufc_link_model u_link (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .rst_req     (rst_req),
        .ulpi_dir    (ulpi_dir),
        .rx_cmd_send (rx_cmd_send),
        .bus_ok      (bus_ok),
        .rxcmd_cnt   (rxcmd_cnt)
    );

    task automatic close_out;
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic give_up;
        fail_count++;
        close_out();
    endtask

    task automatic settle;
        @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [`UFC_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [`UFC_ADDR_W-1:0] a);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask

    task automatic t_reset_values;
        `CHK(phy_ctrl.fs_xcvr_en, 1'b1)
        `CHK(phy_ctrl.hs_xcvr_en, 1'b0)
        rd(`UFC_OFS_FUNC);
        `CHK(rd_val, `UFC_FUNC_RST)
        rd(`UFC_OFS_PULLDOWN);
        `CHK(rd_val, `UFC_PD_RST)
        rd(4'h5);
        `CHK(rd_val, 8'h00)
    endtask

    task automatic t_speed;
        for (int v = 0; v < 4; v++) begin
            wr(`UFC_OFS_FUNC, 8'h40 | 8'(v));
            settle();
            `CHK(phy_ctrl.hs_xcvr_en, 1'(v == 0))
            `CHK(phy_ctrl.fs_xcvr_en, 1'(v == 1 || v == 3))
            `CHK(phy_ctrl.ls_xcvr_en, 1'(v == 2))
            `CHK(phy_ctrl.fs_preamble_en, 1'(v == 3))
        end
    endtask

    // Speed stays high speed so the last mode is legal for the link.
    task automatic t_modes;
        for (int v = 0; v < 4; v++) begin
            wr(`UFC_OFS_FUNC, 8'h40 | 8'(v << 3));
            settle();
            `CHK(phy_ctrl.tx_nondriving, 1'(v == 1))
            `CHK(phy_ctrl.bitstuff_en, 1'(v != 2))
            `CHK(phy_ctrl.nrzi_en, 1'(v != 2))
            `CHK(phy_ctrl.auto_sync_eop_en, 1'(v != 3))
        end
    endtask

    task automatic t_term;
        for (int i = 0; i < 8; i++) begin
            wr(`UFC_OFS_PULLDOWN, TROWS[i][15:8]);
            wr(`UFC_OFS_FUNC, TROWS[i][23:16]);
            settle();
            `CHK(phy_ctrl.term, TROWS[i][2:0])
        end
        wr(`UFC_OFS_PULLDOWN, 8'h00);
    endtask

    task automatic t_set_clr;
        wr(`UFC_OFS_FUNC, 8'h41);
        wr(`UFC_OFS_FUNC_SET, 8'h0c);
        rd(`UFC_OFS_FUNC_SET);
        `CHK(rd_val, 8'h4d)
        wr(`UFC_OFS_FUNC_CLR, 8'h08);
        rd(`UFC_OFS_FUNC_CLR);
        `CHK(rd_val, 8'h45)
    endtask

    task automatic t_suspend;
        wr(`UFC_OFS_FUNC, 8'h01);
        settle();
        `CHK(phy_ctrl.low_power, 1'b1)
        `CHK(phy_ctrl.fs_xcvr_en, 1'b0)
        `CHK(phy_ctrl.fs_rx_en, 1'b1)
        `CHK(phy_ctrl.otg_comp_en, 1'b1)
        rd(`UFC_OFS_STATUS);
        `CHK(rd_val, 8'h01)
        wr(`UFC_OFS_FUNC, 8'h41);
        settle();
        `CHK(phy_ctrl.low_power, 1'b0)
        `CHK(phy_ctrl.fs_xcvr_en, 1'b1)
    endtask

    task automatic t_xcvr_reset;
        int n;
        wr(`UFC_OFS_PULLDOWN, 8'h02);
        wr(`UFC_OFS_FUNC, 8'h6d);
        rst_req <= 1'b1;
        @(posedge core_clk);
        rst_req <= 1'b0;
        #1;
        for (n = 0; n < 4 && ulpi_dir !== 1'b1; n++) settle();
        if (ulpi_dir !== 1'b1) give_up();
        `CHK(xcvr_rst, 1'b1)
        n = 0;
        while (ulpi_dir === 1'b1 && n < 100) begin
            n++;
            settle();
        end
        if (n == 100) give_up();
        `CHK(n, `UFC_XRST_CYC)
        `CHK(xcvr_rst, 1'b0)
        settle();
        `CHK(ulpi_dir, 1'b1)
        `CHK(rx_cmd_send, 1'b1)
        settle();
        `CHK(rx_cmd_send, 1'b0)
        for (n = 0; n < 8 && bus_ok !== 1'b1; n++) settle();
        if (bus_ok !== 1'b1) give_up();
        `CHK(rxcmd_cnt, 1)
        rd(`UFC_OFS_FUNC);
        `CHK(rd_val, 8'h4d)
        rd(`UFC_OFS_PULLDOWN);
        `CHK(rd_val, 8'h02)
    endtask

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    initial begin
        rst_n      = 1'b0;
        reg_addr   = '0;
        reg_wdata  = 8'h00;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        rst_req    = 1'b0;
        fail_count = 0;
        n_checks   = 0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        settle();
        t_reset_values();
        t_speed();
        t_modes();
        t_term();
        t_set_clr();
        t_suspend();
        t_xcvr_reset();
        close_out();
    end
endmodule
